// ### core/adc_ctrl_pkg.sv
// Package: constants for the converter serial control block
package adc_ctrl_pkg;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS     = 8000;
	localparam int CONV_TIME_NS      = 5000;
	localparam int CONV_CYCLES       = (CONV_TIME_NS * 1000) / CLK_PERIOD_PS;
	// ----------------------------------------------------------------
	// Word layout
	// ----------------------------------------------------------------
	localparam int CFG_BITS          = 8;
	localparam int ACQ_BIT           = 6;
	localparam int RESULT_BITS       = 16;
	localparam int CFG_CHAN_LSB      = 4;
	localparam int CFG_CHAN_W        = 4;
	localparam int CFG_RANGE_LSB     = 2;
	localparam int CFG_RANGE_W       = 2;
	localparam int CFG_PWR_LSB       = 0;
	localparam int CFG_PWR_W         = 2;
	localparam logic [7:0] CFG_RESET = 8'h00;

	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_ACQUIRE = 2'b01,
		ST_CONVERT = 2'b10
	} conv_state_t;
endpackage : adc_ctrl_pkg

// ### core/adc_serial_conversion_control.sv
// Module: conversion control and serial port of a sixteen-channel converter
`timescale 1ns/10ps
`default_nettype none
module adc_serial_conversion_control
	import adc_ctrl_pkg::*;
#(
	parameter int CONV_CYC = CONV_CYCLES,
	parameter int RES_W    = RESULT_BITS
) (
	input  wire logic             core_clk_i,
	input  wire logic             sys_rst_i,
	input  wire logic             conversion_start_pulse_i,
	input  wire logic             sck_i,
	input  wire logic             sdi_i,
	input  wire logic             rd_n_i,
	input  wire logic [RES_W-1:0] sample_value_i,
	output logic                  busy_o,
	output logic                  sdo_o,
	output logic                  sdo_oe_o,
	output logic                  acquiring_o,
	output logic [CFG_CHAN_W-1:0] cfg_channel_o,
	output logic [CFG_RANGE_W-1:0] cfg_range_o,
	output logic [CFG_PWR_W-1:0]  cfg_power_o
);
	// ----------------------------------------------------------------
	// Parameter checks
	// ----------------------------------------------------------------
	// Refused at elaboration: the conversion counter is sixteen bits wide,
	// and the result shifter slices one bit below its top, so it needs two;
	// results stop at 32 bits, though the host's word in the bench holds only 16
	if (CONV_CYC < 2 || CONV_CYC > 65535 || RES_W < 2 || RES_W > 32) begin : g_param_check
		$error("adc_serial_conversion_control: unsupported parameters");
	end

	// ----------------------------------------------------------------
	// Input synchronisers: three stages; start, sck and read levels change when stages 1 and 2 agree
	// ----------------------------------------------------------------
	// Stage 0 may settle late; only stages 1 and 2 feed any decision
	logic [2:0] cs_sync;
	logic [2:0] sck_sync;
	logic [2:0] sdi_sync;
	logic [2:0] rd_sync;
	logic       cs_q;
	logic       sck_q;
	logic       rd_q;

	// Reset levels match the idle pins (clock low, read high), so no
	// false edge is seen when reset lets go; the start pin idles low
	// and the first stage simply refills from the pins afterwards
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			cs_sync  <= 3'h0;
			sck_sync <= 3'h0;
			sdi_sync <= 3'h0;
			rd_sync  <= 3'h7;
		end else begin
			cs_sync  <= {cs_sync[1:0], conversion_start_pulse_i};
			sck_sync <= {sck_sync[1:0], sck_i};
			sdi_sync <= {sdi_sync[1:0], sdi_i};
			rd_sync  <= {rd_sync[1:0], rd_n_i};
		end
	end

	// Filtered levels only move when the two late stages agree
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			cs_q  <= 1'b0;
			sck_q <= 1'b0;
			rd_q  <= 1'b1;
		end else begin
			if (cs_sync[1] == cs_sync[2]) cs_q <= cs_sync[2];
			if (sck_sync[1] == sck_sync[2]) sck_q <= sck_sync[2];
			if (rd_sync[1] == rd_sync[2]) rd_q <= rd_sync[2];
		end
	end

	// Edge detection on the filtered levels; an edge needs both late stages
	// to agree, so a pin glitch shorter than a core cycle is never counted
	wire cs_agree   = (cs_sync[1] == cs_sync[2]);
	wire sck_agree  = (sck_sync[1] == sck_sync[2]);
	wire cs_rise    = cs_agree & cs_sync[2] & ~cs_q;
	wire sck_rise   = sck_agree & sck_sync[2] & ~sck_q;
	wire sck_fall   = sck_agree & ~sck_sync[2] & sck_q;
	wire rd_active  = ~rd_q;
	// Sdi passes three stages too, aligned with the sck path
	// No agreement filter on sdi: it is only read at a filtered rise,
	// when the host holds it still
	wire sdi_bit    = sdi_sync[2];

	// ----------------------------------------------------------------
	// Configuration shift-in
	// ----------------------------------------------------------------
	logic [CFG_BITS-1:0] cfg_shift;
	logic [CFG_BITS-1:0] cfg_word;
	logic [3:0]          cfg_count;
	conv_state_t         state;

	// A start edge counts only outside a conversion; one that lands
	// during a conversion is dropped rather than restarting it
	wire start_accept = cs_rise & (state != ST_CONVERT);

	// Counter saturates after eight bits; re-armed by each accepted start
	wire cfg_take   = sck_rise & rd_active & (cfg_count < 4'(CFG_BITS));
	wire cfg_done   = cfg_take & (cfg_count == 4'(CFG_BITS - 1));
	wire acq_enter  = sck_fall & (cfg_count == 4'(ACQ_BIT));
	wire [CFG_BITS-1:0] next_cfg_shift = {cfg_shift[CFG_BITS-2:0], sdi_bit};

	// Shifter takes every accepted bit; the word is latched only when the
	// eighth lands, so a cut frame never leaves half a word on the outputs
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			cfg_shift <= CFG_RESET;
			cfg_word  <= CFG_RESET;
			cfg_count <= 4'h0;
		end else begin
			if (cfg_take) cfg_shift <= next_cfg_shift;
			if (cfg_done) cfg_word <= next_cfg_shift;
			if (start_accept) cfg_count <= 4'h0;
			else if (cfg_take) cfg_count <= cfg_count + 4'h1;
		end
	end

	// Field split of the latched configuration word
	assign cfg_channel_o = cfg_word[CFG_CHAN_LSB +: CFG_CHAN_W];
	assign cfg_range_o   = cfg_word[CFG_RANGE_LSB +: CFG_RANGE_W];
	assign cfg_power_o   = cfg_word[CFG_PWR_LSB +: CFG_PWR_W];

	// ----------------------------------------------------------------
	// Conversion sequencer
	// ----------------------------------------------------------------
	// Sixteen bits cover the longest conversion the parameter check allows
	logic [15:0]      conv_count;
	logic [RES_W-1:0] held_sample;
	logic [RES_W-1:0] out_shift;
	logic             sdo_bit;
	logic             busy_n_int;

	wire conv_end = (state == ST_CONVERT) && (conv_count == 16'(CONV_CYC - 1));
	// Busy rises one cycle after the result lands so the first bit leads it
	wire first_bit_ready = conv_end;

	// Idle and acquiring both accept a start; the sample is held at the
	// edge so a later change on the input cannot disturb the result
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			state       <= ST_IDLE;
			conv_count  <= 16'h0000;
			held_sample <= '0;
			busy_n_int  <= 1'b1;
		end else begin
			case (state)
				ST_IDLE: begin
					if (acq_enter) state <= ST_ACQUIRE;
					if (cs_rise) begin
						state       <= ST_CONVERT;
						conv_count  <= 16'h0000;
						held_sample <= sample_value_i;
						busy_n_int  <= 1'b0;
					end
				end
				ST_ACQUIRE: begin
					if (cs_rise) begin
						state       <= ST_CONVERT;
						conv_count  <= 16'h0000;
						held_sample <= sample_value_i;
						busy_n_int  <= 1'b0;
					end
				end
				ST_CONVERT: begin
					// Further start edges are ignored here
					// Counts core cycles only, so the serial clock cannot stretch it
					conv_count <= conv_count + 16'h0001;
					if (conv_end) state <= ST_IDLE;
				end
				default: state <= ST_IDLE;
			endcase
			// Busy returns high on the idle cycle after the last conversion
			// cycle, one cycle after the first result bit has been loaded
			if (state == ST_IDLE && !cs_rise) busy_n_int <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Result shift-out
	// ----------------------------------------------------------------
	// The load wins over a falling edge in the same cycle; zeros follow the
	// last bit, and nothing shifts while read is high
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			out_shift <= '0;
			sdo_bit   <= 1'b0;
		end else if (first_bit_ready) begin
			out_shift <= {held_sample[RES_W-2:0], 1'b0};
			sdo_bit   <= held_sample[RES_W-1];
		end else if (sck_fall && rd_active) begin
			sdo_bit   <= out_shift[RES_W-1];
			out_shift <= {out_shift[RES_W-2:0], 1'b0};
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Sdo changes only at a result load while disabled; the enable turns the pad off,
	// and it lags the read pin by four core cycles: three synchroniser stages plus the filter
	assign busy_o      = busy_n_int;
	assign sdo_o       = sdo_bit;
	assign sdo_oe_o    = rd_active;
	assign acquiring_o = (state == ST_ACQUIRE);
endmodule : adc_serial_conversion_control
`default_nettype wire

// ### tb/adc_conv_monitor.sv
// Checker: port-level assertions for the conversion control block
`timescale 1ns/10ps
`default_nettype none
module adc_conv_monitor
	import adc_ctrl_pkg::*;
#(
	parameter int CONV_CYC = CONV_CYCLES,
	parameter int RES_W    = RESULT_BITS
) (
	input wire logic                   core_clk_i,
	input wire logic                   sys_rst_i,
	input wire logic                   conversion_start_pulse_i,
	input wire logic                   sck_i,
	input wire logic                   sdi_i,
	input wire logic                   rd_n_i,
	input wire logic [RES_W-1:0]       sample_value_i,
	input wire logic                   busy_o,
	input wire logic                   sdo_o,
	input wire logic                   sdo_oe_o,
	input wire logic                   acquiring_o,
	input wire logic [CFG_CHAN_W-1:0]  cfg_channel_o,
	input wire logic [CFG_RANGE_W-1:0] cfg_range_o,
	input wire logic [CFG_PWR_W-1:0]   cfg_power_o
);
	int   lowcnt;
	int   sck_idle;
	logic sck_q;
	// Busy-low length and cycles since the last serial clock edge
	always_ff @(posedge core_clk_i) begin
		sck_q    <= sck_i;
		lowcnt   <= (sys_rst_i || busy_o) ? 0 : lowcnt + 1;
		sck_idle <= (sys_rst_i || sck_i != sck_q) ? 0 : sck_idle + 1;
	end
	// -------------------------------------------------------------
	// Assertions
	// -------------------------------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);
	chk_oe_off: assert property (rd_n_i [*8] |-> !sdo_oe_o)
		else $error("sdo driven while read high");
	chk_oe_on: assert property (!rd_n_i [*8] |-> sdo_oe_o)
		else $error("sdo idle while read low");
	chk_start_busy: assert property ($rose(conversion_start_pulse_i) && busy_o |-> ##[2:8] !busy_o)
		else $error("start edge gave no busy");
	chk_busy_span: assert property ($rose(busy_o) |-> lowcnt >= CONV_CYC - 1 && lowcnt <= CONV_CYC + 3)
		else $error("busy low span wrong");
	chk_first_bit: assert property ($rose(busy_o) && sdo_oe_o |-> $stable(sdo_o) && sdo_o == sample_value_i[RES_W-1])
		else $error("first bit late at busy rise");
	chk_sdo_hold: assert property (busy_o && $past(busy_o) && sck_idle > 8 |-> $stable(sdo_o))
		else $error("sdo moved without clock fall");
	chk_acq_end: assert property ($rose(conversion_start_pulse_i) && acquiring_o |-> ##[2:8] !acquiring_o && !busy_o)
		else $error("acquisition not ended by start");
	chk_cfg_ignore: assert property (rd_n_i [*8] |-> $stable({cfg_channel_o, cfg_range_o, cfg_power_o}))
		else $error("config changed while read high");
endmodule : adc_conv_monitor
bind adc_serial_conversion_control adc_conv_monitor #(.CONV_CYC(CONV_CYC), .RES_W(RES_W)) i_mon (
	.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .conversion_start_pulse_i(conversion_start_pulse_i),
	.sck_i(sck_i), .sdi_i(sdi_i), .rd_n_i(rd_n_i), .sample_value_i(sample_value_i), .busy_o(busy_o),
	.sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .acquiring_o(acquiring_o), .cfg_channel_o(cfg_channel_o),
	.cfg_range_o(cfg_range_o), .cfg_power_o(cfg_power_o));
`default_nettype wire

// ### tb/host_model.sv
// Host model: serial master that shifts words and starts conversions
`timescale 1ns/10ps
`default_nettype none
module host_model #(
	parameter int ACQ_CYC = 500
) (
	input  wire logic clk_i,
	input  wire logic sdo_i,
	input  wire logic sdo_oe_i,
	output var logic  sck_o,
	output var logic  sdi_o,
	output var logic  rd_n_o,
	output var logic  start_o
);
	initial {sck_o, sdi_o, rd_n_o, start_o} = 4'h2;
	// -------------------------------------------------------------
	// Link tasks
	// -------------------------------------------------------------
	// Half of an 80 ns clock; too fast for rising capture, so capture falls
	task automatic half();
		repeat (5) @(posedge clk_i);
		#1;
	endtask : half
	// Config MSB first on rises, result taken just before each fall
	task automatic xfer(input logic rd_n, input logic [7:0] cfg, output logic [15:0] res);
		rd_n_o = rd_n;
		half();
		for (int i = 15; i >= 0; i--) begin
			sdi_o = (i > 7) ? cfg[i-8] : 1'b0;
			half();
			sck_o = 1'b1;
			half();
			res[i] = sdo_oe_i ? sdo_i : 1'bx;
			sck_o = 1'b0;
		end
		half();
		sdi_o = ~sdi_o; // Released line shows no stale bit
	endtask : xfer
	// High for half a link period, then low as long, so two pulses in a row
	// give the synchroniser two separate rising edges
	task automatic pulse();
		start_o = 1'b1;
		half();
		start_o = 1'b0;
		half();
	endtask : pulse
	task automatic convert();
		repeat (ACQ_CYC) @(posedge clk_i);
		#1;
		pulse();
	endtask : convert
endmodule : host_model
`default_nettype wire

// ### tb/tb_adc_serial_conversion_control.sv
// Testbench: conversion, readback and ignored-input scenarios
`timescale 1ns/10ps
`default_nettype none
module tb_adc_serial_conversion_control;
	import adc_ctrl_pkg::*;
	logic        core_clk_i, sys_rst_i, start, sck, sdi, rd_n, busy, sdo, sdo_oe, acq;
	logic [15:0] sample;
	logic [3:0]  chan;
	logic [1:0]  range, power;
	int          mismatches, check_count, cycles;
	adc_serial_conversion_control #(.CONV_CYC(20)) i_adc_serial_conversion_control (
		.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .conversion_start_pulse_i(start),
		.sck_i(sck), .sdi_i(sdi), .rd_n_i(rd_n), .sample_value_i(sample), .busy_o(busy),
		.sdo_o(sdo), .sdo_oe_o(sdo_oe), .acquiring_o(acq), .cfg_channel_o(chan),
		.cfg_range_o(range), .cfg_power_o(power));
	host_model i_host_model (.clk_i(core_clk_i), .sdo_i(sdo), .sdo_oe_i(sdo_oe), .sck_o(sck),
		.sdi_o(sdi), .rd_n_o(rd_n), .start_o(start));
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic wait_busy(input logic v, input int n);
		for (int i = 0; i < n && busy !== v; i++) @(posedge core_clk_i);
		#1 check(busy, v);
	endtask : wait_busy
	// Configure, convert, restart attempt, then read while loading next word
	task automatic t_convert_read();
		logic [15:0] res;
		i_host_model.xfer(1'b0, 8'h9E, res);
		check({acq, chan, range, power}, 9'h19E);
		i_host_model.convert();
		wait_busy(1'b0, 8);
		check(acq, 1'b0);
		i_host_model.pulse();
		// A honoured restart would keep busy low far past eight cycles
		wait_busy(1'b1, 8);
		i_host_model.xfer(1'b0, 8'h31, res);
		check(res, sample);
		check({chan, range, power, sdo_oe}, 9'h063);
	endtask : t_convert_read
	// Read enable high: bits ignored and output left floating
	task automatic t_read_disabled();
		logic [15:0] res;
		i_host_model.xfer(1'b1, 8'hC4, res);
		i_host_model.convert();
		wait_busy(1'b0, 8);
		wait_busy(1'b1, 40);
		i_host_model.xfer(1'b1, 8'h5A, res);
		check({acq, chan, range, power, sdo_oe}, 10'h062);
	endtask : t_read_disabled
	task automatic give_verdict();
		if (mismatches == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict
	// -------------------------------------------------------------
	// Clock, timeout and main sequence
	// -------------------------------------------------------------
	initial begin
		core_clk_i = 1'b0;
		forever #4 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == 10000) begin
			mismatches++;
			give_verdict();
		end
	end
	initial begin
		sys_rst_i = 1'b1;
		sample = 16'hA5C3;
		repeat (10) @(posedge core_clk_i);
		#1 sys_rst_i = 1'b0;
		t_convert_read();
		t_read_disabled();
		give_verdict();
	end
endmodule : tb_adc_serial_conversion_control
`default_nettype wire
